/* File: exc_pkg.sv */
package exc_pkg;
    localparam logic [31:0] RESET_VECTOR = 32'ha000_0000;
    localparam logic [31:0] OFS_GENERAL = 32'h0000_0100;
    localparam logic [31:0] OFS_XLATE_MISS = 32'h0000_0400;
    localparam logic [31:0] OFS_INTERRUPT = 32'h0000_0600;
    localparam logic [11:0] CODE_COLD = 12'h000;
    localparam logic [11:0] CODE_SOFT = 12'h020;
    localparam logic [11:0] CODE_DEBUG = 12'h000;
    localparam logic [11:0] CODE_MULTI = 12'h140;
    localparam logic [11:0] CODE_FETCH_MISS = 12'h040;
    localparam logic [11:0] CODE_LOAD_MISS = 12'h040;
    localparam logic [11:0] CODE_STORE_MISS = 12'h060;
    localparam logic [11:0] CODE_USER_BREAK = 12'h1e0;
    localparam logic [11:0] CODE_NMI = 12'h1c0;
    localparam logic [3:0] MASK_ALL = 4'hf;
    localparam logic [31:0] VBR_RESET = 32'h0000_0000;
    // status word bit positions
    localparam int SR_FD = 15;
    localparam int SR_BL = 28;
    localparam int SR_RB = 29;
    localparam int SR_MD = 30;
    localparam int SR_IMASK_LO = 4;
    localparam logic [31:0] SR_RESET = 32'h7000_00f0;
    // apb register map
    localparam logic [7:0] A_SYSCALL = 8'h20;
    localparam logic [7:0] A_EXPCODE = 8'h24;
    localparam logic [7:0] A_INTCODE = 8'h28;
    localparam logic [7:0] A_VBASE = 8'h30;
    localparam logic [7:0] A_DBASE = 8'h34;
    localparam logic [7:0] A_CTRL = 8'h38;
    localparam logic [7:0] A_STATUS = 8'h3c;
    localparam logic [7:0] A_SPC = 8'h40;
    localparam logic [7:0] A_SSR = 8'h44;
    localparam logic [7:0] A_SGR = 8'h48;
    localparam int CTRL_UBDE = 0;
    localparam int CTRL_NMI_BLK = 1;
    localparam int TRA_LO = 2;

    typedef enum logic [3:0] {
        GX_NONE = 4'h0,
        GX_USER_BREAK = 4'h1,
        GX_FETCH_MISS = 4'h2,
        GX_LOAD_MISS = 4'h3,
        GX_STORE_MISS = 4'h4,
        GX_OTHER = 4'h5
    } gexc_e;

    typedef struct packed {
        logic valid;
        logic [3:0] order;      // order within general level
        logic [7:0] seq;        // program order, older is smaller
        gexc_e kind;
        logic [11:0] code;      // code for GX_OTHER
        logic reexec;           // re-execution type
        logic [31:0] pc;        // faulting instruction
        logic [31:0] nextPc;    // following instruction
    } gexc_s;

    typedef struct packed {
        logic take;
        logic isReset;
        logic isIntr;
        logic [11:0] code;
        logic [31:0] target;
        logic [31:0] savePc;
    } sel_s;

    typedef struct packed {
        logic [7:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_s;
endpackage

/* File: exc_order_pick.sv */
`timescale 1ns/100ps
// picks the older general exception
module exc_order_pick (
    input wire exc_pkg::gexc_s a,
    input wire exc_pkg::gexc_s b,
    output exc_pkg::gexc_s win
);
    always_comb begin
        if (!b.valid) begin
            win = a;
        end else if (!a.valid) begin
            win = b;
        end else if (a.seq != b.seq) begin
            win = (a.seq < b.seq) ? a : b; // RQ14
        end else begin
            win = (b.order < a.order) ? b : a; // RQ9 RQ13
        end
    end
endmodule // exc_order_pick

/* File: exc_apb_regs.sv */
`timescale 1ns/100ps
// apb address decode
module exc_apb_regs (
    input wire exc_pkg::apb_req_s req,
    output logic wrEn,
    output logic rdEn,
    output logic mapped
);
    always_comb begin
        unique case (req.paddr)
            exc_pkg::A_SYSCALL, exc_pkg::A_EXPCODE, exc_pkg::A_INTCODE,
            exc_pkg::A_VBASE, exc_pkg::A_DBASE, exc_pkg::A_CTRL,
            exc_pkg::A_STATUS, exc_pkg::A_SPC, exc_pkg::A_SSR,
            exc_pkg::A_SGR: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
        wrEn = req.psel && req.penable && req.pwrite;
        rdEn = req.psel && !req.penable && !req.pwrite;
    end
endmodule // exc_apb_regs

/* File: cpu_exception_entry_unit.sv */
`timescale 1ns/100ps
// Behaviour
// [RQ1] on entry save pc, status word and r15 before redirect
// [RQ2] entry sets hold flag, privileged mode and bank select
// [RQ3] only resets clear the fpu disable flag
// [RQ4] code to exception code reg, or interrupt code reg for interrupts
// [RQ5] every reset jumps to one fixed address
// [RQ6] others jump to vector base plus 0x400, 0x600 or 0x100
// [RQ7] resets clear vector base and set mask level to all ones
// [RQ8] cold start 0x000, soft restart 0x020, debug port 0x000
// [RQ9] select by level then order, lower number wins
// [RQ10] reset order: cold/debug 1, soft 2, multi-match 3 and 4 code 0x140
// [RQ11] fetch/load miss 0x040, store miss 0x060, miss offset
// [RQ12] nmi level 3 above level 4 interrupts, code 0x1c0
// [RQ13] decode-time faults share one priority order
// [RQ14] general exceptions taken in program order
// [RQ15] general exception while hold set becomes soft restart; a user break under hold is taken as a user break instead
// [RQ16] blocked case resets only cpu registers, others keep contents
// [RQ17] ordinary interrupts wait while hold flag is set
// [RQ18] nmi under hold pending or taken per software setting
// [RQ19] user break code 0x1e0 goes to debug base when enabled
// [RQ20] return restores pc and status word and resumes there
// [RQ21] return leaves r15 alone
// [RQ22] software sets hold flag before restoring saved state
// [RQ23] syscall loads its 8-bit immediate into syscall register
// [RQ24] 12-bit code fields written by software and hardware
// [RQ25] saved pc is faulting or next instruction by type
// [RQ26] entry flushes all younger in-flight instructions
module cpu_exception_entry_unit (
    input wire logic clk,
    input wire logic nrst,
    input wire logic coldStartReset,
    input wire logic softRestartReset,
    input wire logic debugPortReset,
    input wire logic fetchXlateMultiMatch,
    input wire logic operandXlateMultiMatch,
    input wire exc_pkg::gexc_s gexcDecode,
    input wire exc_pkg::gexc_s gexcMemory,
    input wire logic nmiReq,
    input wire logic extIntReq,
    input wire logic [11:0] extIntCode,
    input wire logic [3:0] extIntLevel,
    input wire logic [31:0] curPc,
    input wire logic [31:0] curR15,
    input wire logic returnFromException,
    input wire logic syscallExec,
    input wire logic [7:0] syscallImm,
    input wire logic srWrite,
    input wire logic [31:0] srWdata,
    input wire exc_pkg::apb_req_s apbReq,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic redirect,
    output logic [31:0] redirectPc,
    output logic flushYounger,
    output logic cpuRegsInit,
    output logic [31:0] statusWord
);
    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_ENTER = 3'b010,
        ST_RETURN = 3'b100
    } phase_e;

    phase_e phase_r;
    logic [31:0] sr_r, spc_r, ssr_r, sgr_r, vbr_r, dbr_r;
    logic [11:0] expCode_r, intCode_r;
    logic [7:0] tra_r;
    logic [1:0] ctrl_r;
    logic nmiPend_r;
    exc_pkg::sel_s sel, pend_r;
    exc_pkg::gexc_s gWin;
    logic wrEn, rdEn, mapped;
    logic holdSet, nmiOk, intOk;

    function automatic logic [31:0] entrySr(input logic [31:0] s,
                                            input logic rst);
        logic [31:0] r;
        r = s;
        r[exc_pkg::SR_BL] = 1'b1; // RQ2
        r[exc_pkg::SR_MD] = 1'b1; // RQ2
        r[exc_pkg::SR_RB] = 1'b1; // RQ2
        if (rst) begin
            r[exc_pkg::SR_FD] = 1'b0; // RQ3
            r[exc_pkg::SR_IMASK_LO +: 4] = exc_pkg::MASK_ALL; // RQ7
        end
        return r;
    endfunction

    function automatic logic [31:0] genWrite(input logic [31:0] old,
                                             input logic [31:0] wd);
        return wrEn ? wd : old;
    endfunction

    exc_order_pick uPick (
        .a(gexcDecode),
        .b(gexcMemory),
        .win(gWin)
    );

    exc_apb_regs uDec (
        .req(apbReq),
        .wrEn(wrEn),
        .rdEn(rdEn),
        .mapped(mapped)
    );

    assign holdSet = sr_r[exc_pkg::SR_BL];
    assign nmiOk = (nmiPend_r || nmiReq) &&
        (!holdSet || !ctrl_r[exc_pkg::CTRL_NMI_BLK]); // RQ18
    assign intOk = extIntReq && !holdSet &&
        (extIntLevel > sr_r[exc_pkg::SR_IMASK_LO +: 4]); // RQ17

    // event arbitration
    always_comb begin
        sel = '0;
        sel.target = exc_pkg::RESET_VECTOR;
        sel.savePc = curPc;
        if (coldStartReset || debugPortReset) begin // RQ10
            sel.take = 1'b1;
            sel.isReset = 1'b1;
            sel.code = coldStartReset ? exc_pkg::CODE_COLD
                                      : exc_pkg::CODE_DEBUG; // RQ8
        end else if (softRestartReset) begin // RQ9
            sel.take = 1'b1;
            sel.isReset = 1'b1;
            sel.code = exc_pkg::CODE_SOFT; // RQ8
        end else if (fetchXlateMultiMatch || operandXlateMultiMatch) begin
            sel.take = 1'b1;
            sel.isReset = 1'b1;
            sel.code = exc_pkg::CODE_MULTI; // RQ10
        end else if (gWin.valid) begin
            sel.take = 1'b1;
            sel.savePc = gWin.reexec ? gWin.pc : gWin.nextPc; // RQ25
            sel.target = vbr_r + exc_pkg::OFS_GENERAL; // RQ6
            unique case (gWin.kind)
                exc_pkg::GX_USER_BREAK: begin
                    sel.code = exc_pkg::CODE_USER_BREAK;
                    if (ctrl_r[exc_pkg::CTRL_UBDE]) begin
                        sel.target = dbr_r; // RQ19
                    end
                end
                exc_pkg::GX_FETCH_MISS: begin
                    sel.code = exc_pkg::CODE_FETCH_MISS; // RQ11
                    sel.target = vbr_r + exc_pkg::OFS_XLATE_MISS;
                end
                exc_pkg::GX_LOAD_MISS: begin
                    sel.code = exc_pkg::CODE_LOAD_MISS; // RQ11
                    sel.target = vbr_r + exc_pkg::OFS_XLATE_MISS;
                end
                exc_pkg::GX_STORE_MISS: begin
                    sel.code = exc_pkg::CODE_STORE_MISS; // RQ11
                    sel.target = vbr_r + exc_pkg::OFS_XLATE_MISS;
                end
                default: sel.code = gWin.code;
            endcase
            if (holdSet && gWin.kind != exc_pkg::GX_USER_BREAK) begin // RQ15
                sel.isReset = 1'b1;
                sel.code = exc_pkg::CODE_SOFT;
                sel.target = exc_pkg::RESET_VECTOR;
            end
        end else if (nmiOk) begin // RQ12
            sel.take = 1'b1;
            sel.isIntr = 1'b1;
            sel.code = exc_pkg::CODE_NMI;
            sel.target = vbr_r + exc_pkg::OFS_INTERRUPT;
        end else if (intOk) begin
            sel.take = 1'b1;
            sel.isIntr = 1'b1;
            sel.code = extIntCode;
            sel.target = vbr_r + exc_pkg::OFS_INTERRUPT; // RQ6
        end
    end

    // one cycle to latch, one to redirect
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            phase_r <= ST_RUN;
            pend_r <= '0;
        end else begin
            unique case (phase_r)
                ST_RUN: begin
                    if (sel.take) begin
                        phase_r <= ST_ENTER;
                        pend_r <= sel;
                    end else if (returnFromException) begin
                        phase_r <= ST_RETURN;
                    end
                end
                ST_ENTER: phase_r <= ST_RUN;
                ST_RETURN: phase_r <= ST_RUN;
                default: phase_r <= ST_RUN;
            endcase
        end
    end

    // a new pulse during acceptance of a pending one stays pending
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            nmiPend_r <= 1'b0;
        end else if (phase_r == ST_RUN && sel.take && sel.isIntr &&
                     sel.code == exc_pkg::CODE_NMI) begin
            nmiPend_r <= nmiReq && nmiPend_r;
        end else if (nmiReq) begin
            nmiPend_r <= 1'b1;
        end
    end

    // save registers and status word
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sr_r <= exc_pkg::SR_RESET;
            spc_r <= '0;
            ssr_r <= '0;
            sgr_r <= '0;
        end else if (phase_r == ST_RUN && sel.take) begin
            spc_r <= sel.savePc; // RQ1
            ssr_r <= sr_r; // RQ1
            sgr_r <= curR15; // RQ1
            sr_r <= entrySr(sr_r, sel.isReset);
        end else if (phase_r == ST_RUN && returnFromException) begin
            sr_r <= ssr_r; // RQ20
        end else if (srWrite) begin
            sr_r <= srWdata;
        end else if (apbReq.paddr == exc_pkg::A_STATUS) begin
            sr_r <= genWrite(sr_r, apbReq.pwdata);
        end else if (apbReq.paddr == exc_pkg::A_SPC) begin
            spc_r <= genWrite(spc_r, apbReq.pwdata);
        end else if (apbReq.paddr == exc_pkg::A_SSR) begin
            ssr_r <= genWrite(ssr_r, apbReq.pwdata);
        end else if (apbReq.paddr == exc_pkg::A_SGR) begin
            sgr_r <= genWrite(sgr_r, apbReq.pwdata);
        end
    end

    // hardware wins over software writes
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            expCode_r <= exc_pkg::CODE_COLD;
            intCode_r <= '0;
            vbr_r <= exc_pkg::VBR_RESET;
            dbr_r <= '0;
            ctrl_r <= '0;
            tra_r <= '0;
        end else begin
            if (phase_r == ST_RUN && sel.take) begin
                if (sel.isIntr) begin
                    intCode_r <= sel.code; // RQ4
                end else begin
                    expCode_r <= sel.code; // RQ24
                end
                if (sel.isReset) begin
                    vbr_r <= exc_pkg::VBR_RESET; // RQ7
                end
            end else if (wrEn) begin
                unique case (apbReq.paddr)
                    exc_pkg::A_EXPCODE: expCode_r <= apbReq.pwdata[11:0];
                    exc_pkg::A_INTCODE: intCode_r <= apbReq.pwdata[11:0];
                    exc_pkg::A_VBASE: vbr_r <= apbReq.pwdata;
                    default: ;
                endcase
            end
            if (syscallExec) begin
                tra_r <= syscallImm; // RQ23
            end else if (wrEn && apbReq.paddr == exc_pkg::A_SYSCALL) begin
                tra_r <= apbReq.pwdata[exc_pkg::TRA_LO +: 8];
            end
            if (wrEn && apbReq.paddr == exc_pkg::A_DBASE) begin
                dbr_r <= apbReq.pwdata;
            end
            if (wrEn && apbReq.paddr == exc_pkg::A_CTRL) begin
                ctrl_r <= apbReq.pwdata[1:0];
            end
        end
    end

    // r15 is never driven back on return
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            redirect <= 1'b0;
            redirectPc <= exc_pkg::RESET_VECTOR;
            flushYounger <= 1'b0;
            cpuRegsInit <= 1'b0;
        end else begin
            redirect <= phase_r == ST_ENTER || phase_r == ST_RETURN;
            flushYounger <= phase_r == ST_RUN &&
                (sel.take || returnFromException); // RQ26
            cpuRegsInit <= phase_r == ST_RUN && sel.take && sel.isReset; // RQ16
            if (phase_r == ST_ENTER) begin
                redirectPc <= pend_r.isReset ? exc_pkg::RESET_VECTOR // RQ5
                                             : pend_r.target;
            end else if (phase_r == ST_RETURN) begin
                redirectPc <= spc_r; // RQ20 RQ21
            end
        end
    end

    // apb read side
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= apbReq.psel && !apbReq.penable;
            pslverr <= apbReq.psel && !apbReq.penable && !mapped;
            if (rdEn) begin
                unique case (apbReq.paddr)
                    exc_pkg::A_SYSCALL: prdata <= {22'h0, tra_r, 2'h0};
                    exc_pkg::A_EXPCODE: prdata <= {20'h0, expCode_r};
                    exc_pkg::A_INTCODE: prdata <= {20'h0, intCode_r};
                    exc_pkg::A_VBASE: prdata <= vbr_r;
                    exc_pkg::A_DBASE: prdata <= dbr_r;
                    exc_pkg::A_CTRL: prdata <= {30'h0, ctrl_r};
                    exc_pkg::A_STATUS: prdata <= sr_r;
                    exc_pkg::A_SPC: prdata <= spc_r;
                    exc_pkg::A_SSR: prdata <= ssr_r;
                    exc_pkg::A_SGR: prdata <= sgr_r;
                    default: prdata <= '0;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            statusWord <= exc_pkg::SR_RESET;
        end else begin
            statusWord <= sr_r;
        end
    end
endmodule // cpu_exception_entry_unit

/* File: cpu_exception_entry_unit_assertions.sv */
`timescale 1ns/100ps
module cpu_exception_entry_unit_checker (
    input wire logic clk,
    input wire logic nrst,
    input wire logic coldStartReset,
    input wire logic softRestartReset,
    input wire logic debugPortReset,
    input wire logic fetchXlateMultiMatch,
    input wire logic operandXlateMultiMatch,
    input wire exc_pkg::gexc_s gexcDecode,
    input wire exc_pkg::gexc_s gexcMemory,
    input wire logic nmiReq,
    input wire logic returnFromException,
    input wire logic redirect,
    input wire logic [31:0] redirectPc,
    input wire logic flushYounger,
    input wire logic [31:0] statusWord
);
    logic anyRst;
    logic anyEv;
    assign anyRst = coldStartReset || softRestartReset || debugPortReset;
    assign anyEv = anyRst || fetchXlateMultiMatch || operandXlateMultiMatch
        || gexcDecode.valid || gexcMemory.valid || nmiReq
        || returnFromException;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_flush_redirect;
        flushYounger |-> ##1 (redirect && !flushYounger);
    endproperty
    a_flush_redirect: assert property (p_flush_redirect)
        else $error("no redirect");
    property p_redirect_cause;
        redirect |-> $past(flushYounger);
    endproperty
    a_redirect_cause: assert property (p_redirect_cause)
        else $error("no flush");
    property p_reset_vec;
        flushYounger && $past(anyRst) |-> ##1
            redirectPc == exc_pkg::RESET_VECTOR;
    endproperty
    a_reset_vec: assert property (p_reset_vec)
        else $error("bad target");
    property p_entry_bits;
        flushYounger && !$past(returnFromException) |-> ##[1:3]
            (statusWord[exc_pkg::SR_BL] && statusWord[exc_pkg::SR_MD]
            && statusWord[exc_pkg::SR_RB]);
    endproperty
    a_entry_bits: assert property (p_entry_bits)
        else $error("entry bits");
    property p_reset_init;
        flushYounger && $past(coldStartReset) |-> ##[1:3]
            (!statusWord[exc_pkg::SR_FD]
            && statusWord[7:4] == exc_pkg::MASK_ALL);
    endproperty
    a_reset_init: assert property (p_reset_init)
        else $error("reset init");
    property p_refuse;
        flushYounger |=> !flushYounger [*2];
    endproperty
    a_refuse: assert property (p_refuse)
        else $error("refusal");
    property p_int_blocked;
        flushYounger && statusWord[exc_pkg::SR_BL] |-> $past(anyEv);
    endproperty
    a_int_blocked: assert property (p_int_blocked)
        else $error("blocked take");
    property p_blocked_soft;
        flushYounger && statusWord[exc_pkg::SR_BL] && $past(gexcDecode.valid
            && gexcDecode.kind != exc_pkg::GX_USER_BREAK) |-> ##1
            redirectPc == exc_pkg::RESET_VECTOR;
    endproperty
    a_blocked_soft: assert property (p_blocked_soft)
        else $error("blocked not reset");
endmodule // cpu_exception_entry_unit_checker

bind cpu_exception_entry_unit cpu_exception_entry_unit_checker u_chk (
    .clk(clk), .nrst(nrst), .coldStartReset(coldStartReset),
    .softRestartReset(softRestartReset), .debugPortReset(debugPortReset),
    .fetchXlateMultiMatch(fetchXlateMultiMatch),
    .operandXlateMultiMatch(operandXlateMultiMatch),
    .gexcDecode(gexcDecode), .gexcMemory(gexcMemory), .nmiReq(nmiReq),
    .returnFromException(returnFromException), .redirect(redirect),
    .redirectPc(redirectPc), .flushYounger(flushYounger),
    .statusWord(statusWord)
);

/* File: exc_source_model.sv */
`timescale 1ns/100ps
// holds requests after an optional lag until the core flushes
module exc_source_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ld,
    input wire logic [7:0] ldVal,
    input wire logic [1:0] lag,
    input wire logic flushYounger,
    output logic [7:0] req
);
    logic [7:0] pend_r;
    logic [1:0] cnt_r;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pend_r <= 8'h00;
            cnt_r <= 2'h0;
        end else if (ld) begin
            pend_r <= ldVal;
            cnt_r <= lag;
        end else if (flushYounger) begin
            pend_r <= 8'h00;
        end else if (cnt_r != 2'h0) begin
            cnt_r <= cnt_r - 2'h1;
        end
    end
    assign req = (cnt_r == 2'h0) ? pend_r : 8'h00;
endmodule // exc_source_model

/* File: cpu_exception_entry_unit_tb_top.sv */
`timescale 1ns/100ps
module cpu_exception_entry_unit_tb_top;
    localparam logic [31:0] VB = 32'h9c08_0000;
    logic clk, nrst, ld, pready, pslverr, redirect, flushYounger, err;
    logic [7:0] ldVal, req, syscallImm;
    logic [1:0] lag;
    logic [2:0] pulses;
    logic [11:0] extIntCode;
    logic [3:0] extIntLevel;
    logic [31:0] curPc, curR15, prdata, redirectPc, statusWord, pc, rd;
    exc_pkg::gexc_s gdBase, gmBase, gd, gm;
    exc_pkg::apb_req_s apbReq;
    int failCount = 0;
    int numChecks = 0;
    int flushCnt = 0;
    int tn = 0;
    int n;
    logic [7:0] rstMask [7] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h03,
        8'h0a};
    logic [11:0] rstCode [7] = '{12'h000, 12'h020, 12'h000, 12'h140,
        12'h140, 12'h000, 12'h020};
    always_comb begin
        gd = gdBase;
        gd.valid = req[5];
        gm = gmBase;
        gm.valid = req[6];
    end
    always @(posedge clk) if (flushYounger) flushCnt <= flushCnt + 1;
    exc_source_model u_src (.clk(clk), .nrst(nrst), .ld(ld),
        .ldVal(ldVal), .lag(lag), .flushYounger(flushYounger), .req(req));
    cpu_exception_entry_unit u_dut (.clk(clk), .nrst(nrst),
        .coldStartReset(req[0]), .softRestartReset(req[1]),
        .debugPortReset(req[2]), .fetchXlateMultiMatch(req[3]),
        .operandXlateMultiMatch(req[4]), .gexcDecode(gd), .gexcMemory(gm),
        .nmiReq(pulses[1]), .extIntReq(req[7]), .extIntCode(extIntCode),
        .extIntLevel(extIntLevel), .curPc(curPc), .curR15(curR15),
        .returnFromException(pulses[0]), .syscallExec(pulses[2]),
        .syscallImm(syscallImm), .srWrite(1'b0), .srWdata(32'h0),
        .apbReq(apbReq), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .redirect(redirect), .redirectPc(redirectPc),
        .flushYounger(flushYounger), .cpuRegsInit(),
        .statusWord(statusWord));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            failCount++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        int k = 0;
        @(posedge clk);
        apbReq <= '{a, 1'b1, 1'b0, w, d};
        @(posedge clk);
        apbReq.penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        apbReq <= '0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic catch_redir();
        int k = 0;
        while (redirect !== 1'b1 && k < 40) begin
            @(posedge clk);
            k++;
        end
        pc = redirectPc;
    endtask
    // p[2]: no redirect expected
    task automatic ev(input logic [7:0] m, input logic [2:0] p,
            input logic [31:0] exp);
        @(posedge clk);
        ld <= 1'b1;
        ldVal <= m;
        @(posedge clk);
        ld <= 1'b0;
        pulses <= p;
        @(posedge clk);
        pulses <= 3'b000;
        if (!p[2]) begin
            catch_redir();
            chk(pc, exp);
        end
    endtask
    function automatic exc_pkg::gexc_s mk(exc_pkg::gexc_e k,
            logic [7:0] s, logic [3:0] o, logic [11:0] c, logic [31:0] p);
        mk = '{1'b0, o, s, k, c, 1'b1, p, p + 32'h2};
    endfunction
    task automatic tdone();
        tn++;
        $display("test %0d done", tn);
    endtask
    task automatic finalReport();
        $display("checks %0d mismatches %0d", numChecks, failCount);
        if (failCount == 0 && numChecks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (6000) @(posedge clk);
        failCount++;
        finalReport();
    end
    initial begin
        nrst = 1'b0;
        ld = 1'b0;
        ldVal = 8'h00;
        lag = 2'h0;
        pulses = 3'b000;
        extIntCode = 12'h0;
        extIntLevel = 4'h0;
        syscallImm = 8'ha5;
        curPc = 32'h0;
        curR15 = 32'h0;
        gdBase = '0;
        gmBase = '0;
        apbReq = '0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        rdchk(exc_pkg::A_STATUS, exc_pkg::SR_RESET);
        chk(redirectPc, exc_pkg::RESET_VECTOR);
        tdone();
        wr(exc_pkg::A_VBASE, VB);
        wr(exc_pkg::A_STATUS, 32'h4000_80f0);
        curPc <= 32'h8c00_1000;
        curR15 <= 32'h1234_5678;
        lag <= 2'h2;
        gmBase <= mk(exc_pkg::GX_STORE_MISS, 8'h3, 4'h6, 12'h0, 32'h8c00_1000);
        ev(8'h40, 3'b000, VB + exc_pkg::OFS_XLATE_MISS);
        lag <= 2'h0;
        rdchk(exc_pkg::A_EXPCODE, 32'h060);
        rdchk(exc_pkg::A_SPC, 32'h8c00_1000);
        rdchk(exc_pkg::A_SSR, 32'h4000_80f0);
        rdchk(exc_pkg::A_SGR, 32'h1234_5678);
        rdchk(exc_pkg::A_STATUS, 32'h7000_80f0);
        tdone();
        curR15 <= 32'h0bad_0001;
        wr(exc_pkg::A_STATUS, 32'h7000_80f0);
        ev(8'h00, 3'b001, 32'h8c00_1000);
        rdchk(exc_pkg::A_STATUS, 32'h4000_80f0);
        rdchk(exc_pkg::A_SGR, 32'h1234_5678);
        tdone();
        gdBase <= mk(exc_pkg::GX_OTHER, 8'h5, 4'h4, 12'h180, 32'h8c00_2000);
        gmBase <= mk(exc_pkg::GX_LOAD_MISS, 8'h3, 4'h6, 12'h0, curPc);
        ev(8'h60, 3'b000, VB + exc_pkg::OFS_XLATE_MISS);
        rdchk(exc_pkg::A_EXPCODE, 32'h040);
        ev(8'h20, 3'b000, exc_pkg::RESET_VECTOR);
        rdchk(exc_pkg::A_EXPCODE, 32'h020);
        rdchk(exc_pkg::A_VBASE, 32'h0);
        tdone();
        wr(exc_pkg::A_VBASE, VB);
        wr(exc_pkg::A_STATUS, 32'h5000_0030);
        extIntLevel <= 4'h5;
        extIntCode <= 12'h2a0;
        n = flushCnt;
        ev(8'h80, 3'b100, 32'h0);
        repeat (8) @(posedge clk);
        chk(flushCnt - n, 0);
        wr(exc_pkg::A_STATUS, 32'h4000_0030);
        catch_redir();
        chk(pc, VB + exc_pkg::OFS_INTERRUPT);
        rdchk(exc_pkg::A_INTCODE, 32'h2a0);
        rdchk(exc_pkg::A_SYSCALL, 32'h294);
        wr(exc_pkg::A_STATUS, 32'h4000_0030);
        ev(8'h80, 3'b010, VB + exc_pkg::OFS_INTERRUPT);
        rdchk(exc_pkg::A_INTCODE, 32'h1c0);
        tdone();
        wr(exc_pkg::A_STATUS, 32'h4000_00f0);
        wr(exc_pkg::A_DBASE, 32'h8000_1000);
        wr(exc_pkg::A_CTRL, 32'h1);
        gmBase <= mk(exc_pkg::GX_USER_BREAK, 8'h1, 4'h0, 12'h0, curPc);
        ev(8'h40, 3'b000, 32'h8000_1000);
        rdchk(exc_pkg::A_EXPCODE, 32'h1e0);
        wr(exc_pkg::A_CTRL, 32'h0);
        wr(exc_pkg::A_STATUS, 32'h4000_00f0);
        ev(8'h40, 3'b000, VB + exc_pkg::OFS_GENERAL);
        tdone();
        for (int i = 0; i < 7; i++) begin
            wr(exc_pkg::A_VBASE, VB);
            wr(exc_pkg::A_STATUS, 32'h4000_80f0);
            ev(rstMask[i], 3'b000, exc_pkg::RESET_VECTOR);
            rdchk(exc_pkg::A_EXPCODE, {20'h0, rstCode[i]});
            rdchk(exc_pkg::A_STATUS, 32'h7000_00f0);
            rdchk(exc_pkg::A_VBASE, 32'h0);
        end
        tdone();
        wr(exc_pkg::A_EXPCODE, 32'h123);
        rdchk(exc_pkg::A_EXPCODE, 32'h123);
        rdchk(8'h10, 32'h0);
        chk({31'h0, err}, 32'h1);
        tdone();
        finalReport();
    end
endmodule // cpu_exception_entry_unit_tb_top
